/* mrf_regs.svh */
`ifndef MRF_REGS_SVH
`define MRF_REGS_SVH

// register number bounds of each map section (inclusive)
`define MRF_FIXED_LO 16'h0001
`define MRF_FIXED_HI 16'h002F
`define MRF_READ_LO 16'h03E8
`define MRF_READ_HI 16'h138B
`define MRF_CMD_LO 16'h4E20
`define MRF_CMD_HI 16'h659B
`define MRF_SET_LO 16'h7530
`define MRF_SET_HI 16'h7573
`define MRF_SEC_LO 16'h9C41
`define MRF_SEC_HI 16'h9CA4

// first register of each item in the fixed section
`define MRF_ID_NAME 6'h01
`define MRF_ID_SERIAL 6'h09
`define MRF_ID_TYPE 6'h11
`define MRF_ID_FW 6'h12
`define MRF_ID_MAP 6'h14
`define MRF_ID_CONFIG 6'h15
`define MRF_ID_ASIC 6'h16
`define MRF_ID_OEM 6'h28

// storage depths of the writable sections
`define MRF_SET_DEPTH 68
`define MRF_SEC_DEPTH 100

// single precision float encoding
`define MRF_EXP_BIAS 8'h7F
`define MRF_MANT_BITS 23

// reset values
`define MRF_WORD_RST 16'h0000
`define MRF_DWORD_RST 32'h0000_0000

`endif

/* mrf_pkg.sv */
package mrf_pkg;

    typedef enum logic [2:0] {
        RG_NONE  = 3'b000,
        RG_FIXED = 3'b001,
        RG_READ  = 3'b010,
        RG_CMD   = 3'b011,
        RG_SET   = 3'b100,
        RG_SEC   = 3'b101
    } mrf_region_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FETCH  = 2'b01,
        ST_ANSWER = 2'b10
    } mrf_state_t;

endpackage

/* mrf_word_ram.sv */
`timescale 1ns/1ps
module mrf_word_ram #(
    parameter int DEPTH = 68,
    parameter int AW = 7
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out
);
    logic [15:0] mem_r [DEPTH];

    // write and read share the edge, so the read register sees the old word (read-before-write)
    always_ff @(posedge clk_in) begin
        if (wr_en_in && (32'(addr_in) < DEPTH)) begin
            mem_r[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (32'(addr_in) < DEPTH) begin
            rdata_out <= mem_r[addr_in];
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule // mrf_word_ram

/* mrf_formatter.sv */
`timescale 1ns/1ps
`include "mrf_regs.svh"

// Operation
// - serve fixed identification information from registers 1 through 47
// - serve measured readings from registers 1000 through 5003
// - accept commands written to registers 20000 through 26011
// - hold basic programmable setup values in registers 30000 through 30067
// - provide secondary readings setup area in registers 40001 through 40100
// - text packs two characters per register, first in upper byte, unterminated
// - 32-bit integers span two registers, upper half at lower number
// - floats span two registers, lower number carries sign and exponent half
// - float exponent is stored with an offset of 127
// - float mantissa has an implied leading one before the fraction
// - float top bit is the sign, one meaning negative
module mrf_formatter
    import mrf_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic rsp_error_out,
    output logic [15:0] rsp_rdata_out,
    input wire logic [127:0] name_text_in,
    input wire logic [127:0] serial_text_in,
    input wire logic [31:0] fw_text_in,
    input wire logic [127:0] oem_text_in,
    input wire logic [15:0] meter_type_in,
    input wire logic [15:0] map_version_in,
    input wire logic [15:0] meter_config_in,
    input wire logic [15:0] asic_version_in,
    output logic reading_rd_out,
    output logic [10:0] reading_idx_out,
    input wire logic [31:0] reading_value_in,
    input wire logic reading_is_float_in,
    output logic cmd_valid_out,
    output logic [15:0] cmd_reg_out,
    output logic [15:0] cmd_data_out
);

    mrf_state_t state_r;
    mrf_region_t region_r;
    logic write_r;
    logic [15:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] offset_r;
    logic set_we_r;
    logic sec_we_r;
    logic [6:0] set_idx_r;
    logic [6:0] sec_idx_r;
    logic [15:0] set_rdata;
    logic [15:0] sec_rdata;
    logic [31:0] snap_r;
    logic [10:0] snap_idx_r;
    logic snap_ok_r;
    logic [31:0] reading_word;
    logic [15:0] answer_data;
    logic answer_error;
    mrf_region_t req_region;

    function automatic mrf_region_t mrf_decode(input logic [15:0] a);
        mrf_region_t r;
        r = RG_NONE;
        if (a >= `MRF_FIXED_LO && a <= `MRF_FIXED_HI) begin
            r = RG_FIXED;
        end else if (a >= `MRF_READ_LO && a <= `MRF_READ_HI) begin
            r = RG_READ;
        end else if (a >= `MRF_CMD_LO && a <= `MRF_CMD_HI) begin
            r = RG_CMD;
        end else if (a >= `MRF_SET_LO && a <= `MRF_SET_HI) begin
            r = RG_SET;
        end else if (a >= `MRF_SEC_LO && a <= `MRF_SEC_HI) begin
            r = RG_SEC;
        end
        return r;
    endfunction

    // picks register k of an eight-register text field, first character in the upper byte
    function automatic logic [15:0] mrf_text_word(input logic [127:0] txt, input logic [2:0] k);
        logic [6:0] top;
        top = 7'h7F - {k, 4'h0};
        return txt[top -: 16];
    endfunction

    // signed integer to single precision; truncates low bits beyond the 24-bit significand
    function automatic logic [31:0] mrf_to_float(input logic [31:0] v);
        logic sgn;
        logic [31:0] mag;
        logic [4:0] pos;
        logic [31:0] norm;
        logic [7:0] expo;
        sgn = v[31];
        mag = sgn ? (~v + 32'h0000_0001) : v;
        pos = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                pos = 5'(i);
            end
        end
        norm = mag << (5'h1F - pos);
        expo = {3'h0, pos} + `MRF_EXP_BIAS;
        if (mag == 32'h0000_0000) begin
            return 32'h0000_0000;
        end
        // leading one of norm is implied and dropped
        return {sgn, expo, norm[30 -: `MRF_MANT_BITS]};
    endfunction

    function automatic logic [15:0] mrf_fixed_word(
        input logic [5:0] n,
        input logic [127:0] name_t,
        input logic [127:0] serial_t,
        input logic [31:0] fw_t,
        input logic [127:0] oem_t,
        input logic [15:0] mtype,
        input logic [15:0] mapv,
        input logic [15:0] mcfg,
        input logic [15:0] asic
    );
        logic [15:0] w;
        w = `MRF_WORD_RST;
        if (n >= `MRF_ID_NAME && n < `MRF_ID_SERIAL) begin
            w = mrf_text_word(name_t, 3'(n - `MRF_ID_NAME));
        end else if (n >= `MRF_ID_SERIAL && n < `MRF_ID_TYPE) begin
            w = mrf_text_word(serial_t, 3'(n - `MRF_ID_SERIAL));
        end else if (n == `MRF_ID_TYPE) begin
            w = mtype;
        end else if (n == `MRF_ID_FW) begin
            w = fw_t[31:16];
        end else if (n == `MRF_ID_FW + 6'h01) begin
            w = fw_t[15:0];
        end else if (n == `MRF_ID_MAP) begin
            w = mapv;
        end else if (n == `MRF_ID_CONFIG) begin
            w = mcfg;
        end else if (n == `MRF_ID_ASIC) begin
            w = asic;
        end else if (n >= `MRF_ID_OEM) begin
            w = mrf_text_word(oem_t, 3'(n - `MRF_ID_OEM));
        end
        return w;
    endfunction

    assign req_region = mrf_decode(req_addr_in);

    // one request in flight; ready drops for the whole fetch/answer walk
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
            req_ready_out <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    req_ready_out <= 1'b1;
                    if (req_valid_in && req_ready_out) begin
                        state_r <= ST_FETCH;
                        req_ready_out <= 1'b0;
                    end
                end
                ST_FETCH: begin
                    state_r <= ST_ANSWER;
                end
                ST_ANSWER: begin
                    state_r <= ST_IDLE;
                    req_ready_out <= 1'b1;
                end
                default: begin
                    state_r <= ST_IDLE;
                    req_ready_out <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            region_r <= RG_NONE;
            write_r <= 1'b0;
            addr_r <= `MRF_WORD_RST;
            wdata_r <= `MRF_WORD_RST;
            offset_r <= `MRF_WORD_RST;
            set_idx_r <= 7'h00;
            sec_idx_r <= 7'h00;
        end else if (state_r == ST_IDLE && req_valid_in && req_ready_out) begin
            region_r <= req_region;
            write_r <= req_write_in;
            addr_r <= req_addr_in;
            wdata_r <= req_wdata_in;
            offset_r <= req_addr_in - `MRF_READ_LO;
            set_idx_r <= 7'(req_addr_in - `MRF_SET_LO);
            sec_idx_r <= 7'(req_addr_in - `MRF_SEC_LO);
        end
    end

    // storage writes land during the fetch cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            set_we_r <= 1'b0;
            sec_we_r <= 1'b0;
        end else begin
            set_we_r <= state_r == ST_IDLE && req_valid_in && req_ready_out && req_write_in && req_region == RG_SET;
            sec_we_r <= state_r == ST_IDLE && req_valid_in && req_ready_out && req_write_in && req_region == RG_SEC;
        end
    end

    mrf_word_ram #(
        .DEPTH(`MRF_SET_DEPTH),
        .AW(7)
    ) u_set_ram (
        .clk_in(clk_in),
        .wr_en_in(set_we_r),
        .addr_in(set_idx_r),
        .wdata_in(wdata_r),
        .rdata_out(set_rdata)
    );

    mrf_word_ram #(
        .DEPTH(`MRF_SEC_DEPTH),
        .AW(7)
    ) u_sec_ram (
        .clk_in(clk_in),
        .wr_en_in(sec_we_r),
        .addr_in(sec_idx_r),
        .wdata_in(wdata_r),
        .rdata_out(sec_rdata)
    );

    // the reading source answers on the cycle after the fetch pulse
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reading_rd_out <= 1'b0;
            reading_idx_out <= 11'h000;
        end else begin
            reading_rd_out <= state_r == ST_IDLE && req_valid_in && req_ready_out && !req_write_in
                && req_region == RG_READ;
            if (state_r == ST_IDLE && req_valid_in && req_ready_out) begin
                reading_idx_out <= 11'((req_addr_in - `MRF_READ_LO) >> 1);
            end
        end
    end

    assign reading_word = reading_is_float_in ? mrf_to_float(reading_value_in) : reading_value_in;

    always_comb begin
        answer_data = `MRF_WORD_RST;
        answer_error = 1'b0;
        case (region_r)
            RG_FIXED: begin
                answer_error = write_r;
                if (!write_r) begin
                    answer_data = mrf_fixed_word(addr_r[5:0], name_text_in, serial_text_in, fw_text_in,
                        oem_text_in, meter_type_in, map_version_in, meter_config_in, asic_version_in);
                end
            end
            RG_READ: begin
                answer_error = write_r;
                if (!write_r && !offset_r[0]) begin
                    answer_data = reading_word[31:16];
                end else if (!write_r && snap_ok_r && snap_idx_r == reading_idx_out) begin
                    answer_data = snap_r[15:0];
                end else if (!write_r) begin
                    answer_data = reading_word[15:0];
                end
            end
            RG_CMD: begin
                answer_data = `MRF_WORD_RST;
            end
            RG_SET: begin
                answer_data = write_r ? `MRF_WORD_RST : set_rdata;
            end
            RG_SEC: begin
                answer_data = write_r ? `MRF_WORD_RST : sec_rdata;
            end
            default: begin
                answer_error = 1'b1;
            end
        endcase
    end

    // the upper-half read latches the whole word so the lower half cannot tear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            snap_r <= `MRF_DWORD_RST;
            snap_idx_r <= 11'h000;
            snap_ok_r <= 1'b0;
        end else if (state_r == ST_ANSWER && region_r == RG_READ && !write_r) begin
            if (!offset_r[0]) begin
                snap_r <= reading_word;
                snap_idx_r <= reading_idx_out;
                snap_ok_r <= 1'b1;
            end else begin
                snap_ok_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_error_out <= 1'b0;
            rsp_rdata_out <= `MRF_WORD_RST;
        end else begin
            rsp_valid_out <= state_r == ST_ANSWER;
            if (state_r == ST_ANSWER) begin
                rsp_error_out <= answer_error;
                rsp_rdata_out <= answer_data;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_valid_out <= 1'b0;
            cmd_reg_out <= `MRF_WORD_RST;
            cmd_data_out <= `MRF_WORD_RST;
        end else begin
            cmd_valid_out <= state_r == ST_ANSWER && region_r == RG_CMD && write_r;
            if (state_r == ST_ANSWER && region_r == RG_CMD && write_r) begin
                cmd_reg_out <= addr_r;
                cmd_data_out <= wdata_r;
            end
        end
    end

endmodule // mrf_formatter

/* mrf_formatter_asserts.sv */
`timescale 1ns/1ps
`include "mrf_regs.svh"
module mrf_formatter_asserts (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic rsp_error_out,
    input wire logic [15:0] rsp_rdata_out,
    input wire logic [127:0] name_text_in,
    input wire logic reading_rd_out,
    input wire logic [10:0] reading_idx_out,
    input wire logic [31:0] reading_value_in,
    input wire logic reading_is_float_in,
    input wire logic cmd_valid_out,
    input wire logic [15:0] cmd_reg_out,
    input wire logic [15:0] cmd_data_out
);
    logic tk, fix, rdg, cmd, stg;
    assign tk = req_valid_in && req_ready_out;
    assign fix = req_addr_in >= `MRF_FIXED_LO && req_addr_in <= `MRF_FIXED_HI;
    assign rdg = req_addr_in >= `MRF_READ_LO && req_addr_in <= `MRF_READ_HI;
    assign cmd = req_addr_in >= `MRF_CMD_LO && req_addr_in <= `MRF_CMD_HI;
    assign stg = (req_addr_in >= `MRF_SET_LO && req_addr_in <= `MRF_SET_HI)
        || (req_addr_in >= `MRF_SEC_LO && req_addr_in <= `MRF_SEC_HI);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    sequence s_err;
        ##3 rsp_valid_out && rsp_error_out;
    endsequence
    sequence s_ok;
        ##3 rsp_valid_out && !rsp_error_out;
    endsequence
    // ready stays low through fetch and answer, so only one request is ever in flight
    sequence s_busy;
        !req_ready_out ##1 !req_ready_out;
    endsequence
    sequence s_hi_float;
        tk && !req_write_in && rdg && !req_addr_in[0] ##2 reading_is_float_in && reading_value_in != 32'h0000_0000;
    endsequence
    chk_fixed_read: assert property (tk && !req_write_in && fix |-> s_ok)
        else $error("fixed area read refused");
    chk_text_order: assert property (tk && !req_write_in && req_addr_in == 16'h0001
        |-> ##3 rsp_rdata_out == $past(name_text_in[127:112], 3)) else $error("text byte order wrong");
    chk_ro_error: assert property (tk && req_write_in && (fix || rdg) |-> s_err)
        else $error("read-only write accepted");
    chk_read_fetch: assert property (tk && !req_write_in && rdg |=> reading_rd_out
        && {5'h00, reading_idx_out} == ($past(req_addr_in) - 16'h03E8) >> 1) else $error("bad slot fetch");
    chk_cmd_pulse: assert property (tk && req_write_in && cmd |-> ##3 cmd_valid_out && rsp_valid_out
        && cmd_reg_out == $past(req_addr_in, 3) && cmd_data_out == $past(req_wdata_in, 3))
        else $error("command not passed on");
    chk_cmd_cause: assert property (cmd_valid_out |-> rsp_valid_out && !rsp_error_out)
        else $error("stray command pulse");
    chk_cmd_read: assert property (tk && !req_write_in && cmd |-> ##3 rsp_valid_out
        && rsp_rdata_out == 16'h0000 && !cmd_valid_out) else $error("command read wrong");
    chk_setup_ok: assert property (tk && stg |-> s_ok)
        else $error("setup area refused");
    chk_unmapped_err: assert property (tk && !(fix || rdg || cmd || stg) |-> s_err)
        else $error("unmapped access accepted");
    chk_float_sign: assert property (s_hi_float |=> rsp_rdata_out[15] == $past(reading_value_in[31]))
        else $error("float sign wrong");
    chk_single_flight: assert property (tk |=> s_busy ##1 req_ready_out && rsp_valid_out ##1 !rsp_valid_out)
        else $error("request overlap or answer pulse wrong");
endmodule // mrf_formatter_asserts

bind mrf_formatter mrf_formatter_asserts u_chk (.clk_in(clk_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_error_out(rsp_error_out), .rsp_rdata_out(rsp_rdata_out), .name_text_in(name_text_in),
    .reading_rd_out(reading_rd_out), .reading_idx_out(reading_idx_out), .reading_value_in(reading_value_in),
    .reading_is_float_in(reading_is_float_in), .cmd_valid_out(cmd_valid_out), .cmd_reg_out(cmd_reg_out),
    .cmd_data_out(cmd_data_out));

/* mrf_reading_src.sv */
`timescale 1ns/1ps
module mrf_reading_src (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [10:0] idx_in,
    input wire logic [15:0] gen_in,
    output logic [31:0] value_out,
    output logic is_float_out
);
    // the value stands only in the cycle after the fetch pulse, then scrambles
    always_ff @(posedge clk_in) begin
        if (rd_in) begin
            is_float_out <= idx_in[0];
            case (idx_in[1:0])
                2'h0: value_out <= {16'h1234 + gen_in, 16'h5678 + gen_in};
                2'h1: value_out <= 32'hFFFF_F8F8;
                2'h2: value_out <= 32'h0000_0002;
                default: value_out <= 32'h0000_0001;
            endcase
        end else begin
            value_out <= ~value_out;
            is_float_out <= ~is_float_out;
        end
    end
endmodule // mrf_reading_src

/* mrf_formatter_test.sv */
`timescale 1ns/1ps
module mrf_formatter_test;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [15:0] req_addr_in = 16'h0000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [15:0] gen = 16'h0000;
    logic [127:0] name_t = "ABCDEFGHIJKLMNOP";
    logic [127:0] ser_t = "0123456789ABCDEF";
    logic [127:0] oem_t = "QRSTUVWXYZabcdef";
    logic [31:0] fw_t = "V102";
    logic req_ready_out, rsp_valid_out, rsp_error_out, rd_p, is_f, cmd_valid_out, er, cv;
    logic [15:0] rsp_rdata_out, cmd_reg_out, cmd_data_out, rd, cr, cd;
    logic [10:0] idx;
    logic [31:0] val;
    int failures = 0;
    int cmp_count = 0;
    logic [15:0] fa [13] = '{16'h0001, 16'h0008, 16'h0009, 16'h0011, 16'h0012, 16'h0013, 16'h0014,
        16'h0015, 16'h0016, 16'h0017, 16'h0027, 16'h0028, 16'h002F};
    logic [15:0] fe [13] = '{16'h4142, 16'h4F50, 16'h3031, 16'h0A01, 16'h5631, 16'h3032, 16'h0003,
        16'h003C, 16'h0007, 16'h0000, 16'h0000, 16'h5152, 16'h6566};
    logic [15:0] ea [14] = '{16'h0001, 16'h002F, 16'h03E8, 16'h138B, 16'h0000, 16'h0030, 16'h03E7,
        16'h138C, 16'h4E1F, 16'h659C, 16'h752F, 16'h7574, 16'h9C40, 16'h9CA5};
    logic [15:0] ra [10] = '{16'h03E8, 16'h03E9, 16'h03EA, 16'h03EB, 16'h03EC, 16'h03ED, 16'h03EE,
        16'h03EF, 16'h138A, 16'h138B};
    logic [15:0] re [10] = '{16'h1234, 16'h5678, 16'hC4E1, 16'h0000, 16'h0000, 16'h0002, 16'h3F80,
        16'h0000, 16'hC4E1, 16'h0000};
    logic [15:0] wa [4] = '{16'h7530, 16'h7573, 16'h9C41, 16'h9CA4};

    mrf_formatter u_dut (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_error_out(rsp_error_out),
        .rsp_rdata_out(rsp_rdata_out), .name_text_in(name_t), .serial_text_in(ser_t), .fw_text_in(fw_t),
        .oem_text_in(oem_t), .meter_type_in(16'h0A01), .map_version_in(16'h0003),
        .meter_config_in(16'h003C), .asic_version_in(16'h0007), .reading_rd_out(rd_p),
        .reading_idx_out(idx), .reading_value_in(val), .reading_is_float_in(is_f),
        .cmd_valid_out(cmd_valid_out), .cmd_reg_out(cmd_reg_out), .cmd_data_out(cmd_data_out));
    mrf_reading_src u_src (.clk_in(clk_in), .rd_in(rd_p), .idx_in(idx), .gen_in(gen),
        .value_out(val), .is_float_out(is_f));

    always #5 clk_in = ~clk_in;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until an edge that sees ready, then waits for the answer pulse
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        req_write_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        req_valid_in = 1'b1;
        while (req_ready_out !== 1'b1 && n < 20) begin
            @(posedge clk_in) #1;
            n++;
        end
        @(posedge clk_in) #1;
        req_valid_in = 1'b0;
        while (rsp_valid_out !== 1'b1 && n < 20) begin
            @(posedge clk_in) #1;
            n++;
        end
        if (n >= 20) failures++;
        rd = rsp_rdata_out;
        er = rsp_error_out;
        cv = cmd_valid_out;
        cr = cmd_reg_out;
        cd = cmd_data_out;
    endtask
    task automatic rq(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
        xfer(w, a, d);
        chk(rd, e);
        chk({15'h0000, er}, 16'h0000);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic t_fixed();
        for (int i = 0; i < 13; i++) begin
            rq(1'b0, fa[i], 16'h0000, fe[i]);
        end
        done("fixed");
    endtask
    task automatic t_errors();
        for (int i = 0; i < 14; i++) begin
            xfer(i < 4, ea[i], 16'hFFFF);
            chk({15'h0000, er}, 16'h0001);
        end
        done("errors");
    endtask
    task automatic t_read();
        for (int i = 0; i < 10; i++) begin
            rq(1'b0, ra[i], 16'h0000, re[i]);
        end
        done("readings");
    endtask
    task automatic t_snap();
        rq(1'b0, 16'h03E8, 16'h0000, 16'h1234);
        gen = 16'h0001;
        rq(1'b0, 16'h03E9, 16'h0000, 16'h5678);
        rq(1'b0, 16'h03E9, 16'h0000, 16'h5679);
        rq(1'b0, 16'h03E8, 16'h0000, 16'h1235);
        rq(1'b0, 16'h03EA, 16'h0000, 16'hC4E1);
        rq(1'b0, 16'h03E9, 16'h0000, 16'h5679);
        done("snapshot");
    endtask
    task automatic t_cmd();
        for (int i = 0; i < 2; i++) begin
            rq(1'b1, i ? 16'h659B : 16'h4E20, 16'hA5A5 ^ 16'(i), 16'h0000);
            chk({15'h0000, cv}, 16'h0001);
            chk(cr, i ? 16'h659B : 16'h4E20);
            chk(cd, 16'hA5A5 ^ 16'(i));
        end
        rq(1'b0, 16'h4E20, 16'h0000, 16'h0000);
        chk({15'h0000, cv}, 16'h0000);
        done("commands");
    endtask
    task automatic t_ram();
        for (int i = 0; i < 4; i++) begin
            rq(1'b1, wa[i], ~wa[i], 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            rq(1'b0, wa[i], 16'h0000, ~wa[i]);
        end
        done("settings");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #50000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        @(posedge clk_in) #1;
        t_fixed();
        t_errors();
        t_read();
        t_snap();
        t_cmd();
        t_ram();
        wrap_up();
    end
endmodule // mrf_formatter_test
